//--- verilog/vrt_ctrl.sv
// Controller end: sequences reference training commands and their delays.
//
// Contract
// [R01] Entry is register write, bit7 high, bit6 range.
// [R02] Wait entry delay before training commands.
// [R03] In training only listed commands are allowed.
// [R04] Dummy writes allowed before first adjustment.
// [R05] Set command: bit7 high, same range, code.
// [R06] Bit7 low leaves range and code untouched.
// [R07] Wait settling time after each setting.
// [R08] Addressing per device: only setting and exit.
// [R09] Last range and code kept after exit.
// [R10] Exit only when all banks idle.
// [R11] Only deselects until exit delay has elapsed.
// [R12] Exit command carries no new value.
// [R13] Settle per last step size before exit.
// [R14] Range chosen only at entry.
// [R15] Train only after initialization completes.
// [R16] Bit6 chooses range one or range two.
// [R17] Bits 6:0 change only while bit7 set.
// [R18] Per device: data bit zero low executes.
// [R19] Device training flag set, cleared, reset.
// [R20] Counters hold off commands until delays expire.
`timescale 1ns/1ps
module vrt_ctrl #(
    parameter int ENTRY_CYC = vrt_pkg::ENTRY_CYC,
    parameter int EXIT_CYC = vrt_pkg::EXIT_CYC,
    parameter int SETTLE_SHORT_CYC = vrt_pkg::SETTLE_SHORT_CYC,
    parameter int SETTLE_LONG_CYC = vrt_pkg::SETTLE_LONG_CYC
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic init_done_i,
    input wire logic req_valid_i,
    input wire vrt_pkg::vrt_op_t req_op_i,
    input wire logic req_range_i,
    input wire logic [5:0] req_code_i,
    input wire logic [1:0] req_bank_i,
    input wire logic [vrt_pkg::ADDR_W-1:0] req_addr_i,
    input wire logic req_skip_i,
    output logic req_ready_o,
    output logic req_err_o,
    output logic training_o,
    vrt_if.ctrl bus
);
    // ****************************************
    // Helpers
    // ****************************************
    typedef enum logic [1:0] {
        VRT_ST_IDLE,
        VRT_ST_TRAIN,
        VRT_ST_EXIT
    } vrt_state_t;

    function automatic logic [vrt_pkg::CNT_W-1:0] vrt_settle(input logic [5:0] a,
                                                              input logic [5:0] b);
        logic [5:0] d;
        d = (a > b) ? a - b : b - a;
        // A single step settles fast; anything wider takes the full step time.
        if (d <= 6'h01) begin
            vrt_settle = vrt_pkg::CNT_W'(SETTLE_SHORT_CYC);
        end else begin
            vrt_settle = vrt_pkg::CNT_W'(SETTLE_LONG_CYC);
        end
    endfunction : vrt_settle

    function automatic logic vrt_is_array(input vrt_pkg::vrt_op_t op);
        vrt_is_array = (op == vrt_pkg::VRT_OP_ACT) || (op == vrt_pkg::VRT_OP_WR) ||
                       (op == vrt_pkg::VRT_OP_WRA) || (op == vrt_pkg::VRT_OP_RD) ||
                       (op == vrt_pkg::VRT_OP_RDA) || (op == vrt_pkg::VRT_OP_PRE);
    endfunction : vrt_is_array

    // ****************************************
    // Registers
    // ****************************************
    vrt_state_t state_reg;
    vrt_state_t state_next;
    logic [vrt_pkg::CNT_W-1:0] cnt_reg;
    logic [vrt_pkg::CNT_W-1:0] cnt_next;
    logic range_reg;
    logic [5:0] code_reg;
    logic [5:0] code_next;
    logic pda_reg;
    logic pda_next;
    logic [3:0] open_reg;
    logic [3:0] open_next;
    logic ready_reg;
    logic err_reg;
    vrt_pkg::vrt_cmd_t cmd_reg;
    vrt_pkg::vrt_cmd_t cmd_next;
    logic [vrt_pkg::BA_W-1:0] ba_reg;
    logic [vrt_pkg::BA_W-1:0] ba_next;
    logic [vrt_pkg::ADDR_W-1:0] addr_reg;
    logic [vrt_pkg::ADDR_W-1:0] addr_next;
    logic dq0_reg;
    logic dq0_oe_reg;

    // ****************************************
    // Legality
    // ****************************************
    wire take = req_valid_i && ready_reg;
    wire in_train = (state_reg == VRT_ST_TRAIN);
    wire is_mrs_op = (req_op_i == vrt_pkg::VRT_OP_SET) || (req_op_i == vrt_pkg::VRT_OP_EXIT);
    wire ok_enter = (state_reg == VRT_ST_IDLE) && init_done_i; // [R15]
    // Ready returns after the entry, settle or exit counter drains, and one cycle after a refused request.
    wire ok_train = in_train && (is_mrs_op || (!pda_reg && vrt_is_array(req_op_i))); // [R03] [R08]
    wire ok_exit = in_train && (open_reg == 4'h0); // [R10]
    wire ok_pda = (state_reg == VRT_ST_IDLE);
    wire ok_plain = (state_reg == VRT_ST_IDLE) && !pda_reg && vrt_is_array(req_op_i);
    logic legal;
    always_comb begin
        case (req_op_i)
            vrt_pkg::VRT_OP_ENTER: legal = ok_enter;
            vrt_pkg::VRT_OP_EXIT: legal = ok_exit;
            vrt_pkg::VRT_OP_SET: legal = ok_train;
            vrt_pkg::VRT_OP_PDA_ON: legal = ok_pda;
            vrt_pkg::VRT_OP_PDA_OFF: legal = ok_pda;
            default: legal = ok_train || ok_plain; // [R04]
        endcase
    end
    wire go = take && legal;
    wire [vrt_pkg::CNT_W-1:0] settle_cyc = vrt_settle(code_reg, req_code_i);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        state_next = state_reg;
        cnt_next = (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg; // [R20]
        code_next = code_reg;
        pda_next = pda_reg;
        open_next = open_reg;
        cmd_next = vrt_pkg::VRT_CMD_DES;
        ba_next = '0;
        addr_next = '0;
        // Leave the exit state on the edge that raises ready, so the next request is legal.
        if (state_reg == VRT_ST_EXIT && cnt_next <= 1) begin // [R11]
            state_next = VRT_ST_IDLE;
        end
        if (go) begin
            case (req_op_i)
                vrt_pkg::VRT_OP_ENTER: begin
                    cmd_next = vrt_pkg::VRT_CMD_MRS;
                    ba_next = vrt_pkg::REFERENCE_CONFIG_REGISTER;
                    addr_next[vrt_pkg::TRAIN_EN_BIT] = 1'b1; // [R01]
                    addr_next[vrt_pkg::RANGE_BIT] = req_range_i; // [R01] [R16]
                    state_next = VRT_ST_TRAIN;
                    cnt_next = vrt_pkg::CNT_W'(ENTRY_CYC); // [R02]
                end
                vrt_pkg::VRT_OP_SET: begin
                    cmd_next = vrt_pkg::VRT_CMD_MRS;
                    ba_next = vrt_pkg::REFERENCE_CONFIG_REGISTER;
                    addr_next[vrt_pkg::TRAIN_EN_BIT] = 1'b1; // [R05]
                    addr_next[vrt_pkg::RANGE_BIT] = range_reg; // [R14]
                    addr_next[vrt_pkg::CODE_MSB:0] = req_code_i; // [R05]
                    if (!req_skip_i) begin
                        code_next = req_code_i;
                    end
                    cnt_next = settle_cyc; // [R07] [R13]
                end
                vrt_pkg::VRT_OP_EXIT: begin
                    cmd_next = vrt_pkg::VRT_CMD_MRS;
                    ba_next = vrt_pkg::REFERENCE_CONFIG_REGISTER;
                    addr_next[vrt_pkg::RANGE_BIT] = range_reg; // [R12]
                    addr_next[vrt_pkg::CODE_MSB:0] = code_reg; // [R12]
                    state_next = VRT_ST_EXIT;
                    cnt_next = vrt_pkg::CNT_W'(EXIT_CYC); // [R11]
                end
                vrt_pkg::VRT_OP_PDA_ON, vrt_pkg::VRT_OP_PDA_OFF: begin
                    cmd_next = vrt_pkg::VRT_CMD_MRS;
                    ba_next = vrt_pkg::PDA_CONFIG_REGISTER;
                    addr_next[vrt_pkg::PDA_EN_BIT] = (req_op_i == vrt_pkg::VRT_OP_PDA_ON);
                    pda_next = (req_op_i == vrt_pkg::VRT_OP_PDA_ON);
                end
                default: begin
                    ba_next = {1'b0, req_bank_i};
                    addr_next = req_addr_i;
                    case (req_op_i)
                        vrt_pkg::VRT_OP_ACT: cmd_next = vrt_pkg::VRT_CMD_ACT;
                        vrt_pkg::VRT_OP_WR: cmd_next = vrt_pkg::VRT_CMD_WR;
                        vrt_pkg::VRT_OP_WRA: cmd_next = vrt_pkg::VRT_CMD_WRA;
                        vrt_pkg::VRT_OP_RD: cmd_next = vrt_pkg::VRT_CMD_RD;
                        vrt_pkg::VRT_OP_RDA: cmd_next = vrt_pkg::VRT_CMD_RDA;
                        default: cmd_next = vrt_pkg::VRT_CMD_PRE;
                    endcase
                    open_next[req_bank_i] = (req_op_i == vrt_pkg::VRT_OP_ACT) ||
                        (open_reg[req_bank_i] && ((req_op_i == vrt_pkg::VRT_OP_WR) ||
                                                  (req_op_i == vrt_pkg::VRT_OP_RD)));
                end
            endcase
        end
    end
    wire start_train = go && (req_op_i == vrt_pkg::VRT_OP_ENTER);

    // ****************************************
    // Flip-flops
    // ****************************************
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= VRT_ST_IDLE;
            cnt_reg <= '0;
            range_reg <= vrt_pkg::RANGE_RESET;
            code_reg <= vrt_pkg::CODE_RESET;
            pda_reg <= 1'b0;
            open_reg <= 4'h0;
            ready_reg <= 1'b0;
            err_reg <= 1'b0;
            cmd_reg <= vrt_pkg::VRT_CMD_DES;
            ba_reg <= '0;
            addr_reg <= '0;
            dq0_reg <= 1'b0;
            dq0_oe_reg <= 1'b0;
        end else if (ce_i) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            if (start_train) begin
                range_reg <= req_range_i; // [R14]
            end
            code_reg <= code_next;
            pda_reg <= pda_next;
            open_reg <= open_next;
            // A refused request costs one idle cycle so the error pulse pairs with it.
            ready_reg <= (cnt_next <= 1) && !(take && !legal);
            err_reg <= take && !legal;
            cmd_reg <= cmd_next;
            ba_reg <= ba_next;
            addr_reg <= addr_next;
            // Under per-device addressing a skipped device sees data bit zero high.
            dq0_reg <= go && pda_reg && req_skip_i; // [R18]
            dq0_oe_reg <= go && pda_reg && (cmd_next == vrt_pkg::VRT_CMD_MRS);
        end
    end

    assign req_ready_o = ready_reg;
    assign req_err_o = err_reg;
    assign training_o = (state_reg == VRT_ST_TRAIN);
    assign bus.cmd = cmd_reg;
    assign bus.ba = ba_reg;
    assign bus.addr = addr_reg;
    assign bus.data_bit_zero_o = dq0_reg;
    assign bus.data_bit_zero_oe = dq0_oe_reg;
endmodule : vrt_ctrl

//--- inc/vrt_pkg.sv
// Shared constants and types for the reference training mode ends.
package vrt_pkg;
    // ****************************************
    // Command encoding on the shared bus
    // ****************************************
    typedef enum logic [3:0] {
        VRT_CMD_DES,
        VRT_CMD_ACT,
        VRT_CMD_WR,
        VRT_CMD_WRA,
        VRT_CMD_RD,
        VRT_CMD_RDA,
        VRT_CMD_PRE,
        VRT_CMD_MRS
    } vrt_cmd_t;

    // ****************************************
    // Controller user operations
    // ****************************************
    typedef enum logic [3:0] {
        VRT_OP_ENTER,
        VRT_OP_SET,
        VRT_OP_EXIT,
        VRT_OP_PDA_ON,
        VRT_OP_PDA_OFF,
        VRT_OP_ACT,
        VRT_OP_WR,
        VRT_OP_WRA,
        VRT_OP_RD,
        VRT_OP_RDA,
        VRT_OP_PRE
    } vrt_op_t;

    // ****************************************
    // Register addressing and field positions
    // ****************************************
    localparam int ADDR_W = 14;
    localparam int BA_W = 3;
    localparam logic [2:0] REFERENCE_CONFIG_REGISTER = 3'h6;
    localparam logic [2:0] PDA_CONFIG_REGISTER = 3'h3;
    localparam int TRAIN_EN_BIT = 7;
    localparam int RANGE_BIT = 6;
    localparam int CODE_MSB = 5;
    localparam int PDA_EN_BIT = 4;
    localparam logic [5:0] CODE_RESET = 6'h00;
    localparam logic RANGE_RESET = 1'b0;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ = 20;
    localparam int TRAINING_ENTRY_DELAY_NS = 150;
    localparam int TRAINING_EXIT_DELAY_NS = 150;
    localparam int SETTLE_SHORT_NS = 80;
    localparam int SETTLE_LONG_NS = 250;
    localparam int CNT_W = 8;
    localparam int ENTRY_CYC = (TRAINING_ENTRY_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int EXIT_CYC = (TRAINING_EXIT_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int SETTLE_SHORT_CYC = (SETTLE_SHORT_NS * CLK_MHZ + 999) / 1000;
    localparam int SETTLE_LONG_CYC = (SETTLE_LONG_NS * CLK_MHZ + 999) / 1000;
endpackage : vrt_pkg

//--- inc/vrt_if.sv
// Command bus between the memory controller and the DRAM training logic.
`timescale 1ns/1ps
interface vrt_if;
    vrt_pkg::vrt_cmd_t cmd;
    logic [vrt_pkg::BA_W-1:0] ba;
    logic [vrt_pkg::ADDR_W-1:0] addr;
    logic data_bit_zero_o;
    logic data_bit_zero_oe;

    modport ctrl (
        output cmd,
        output ba,
        output addr,
        output data_bit_zero_o,
        output data_bit_zero_oe
    );

    modport dev (
        input cmd,
        input ba,
        input addr,
        input data_bit_zero_o,
        input data_bit_zero_oe
    );
endinterface : vrt_if

//--- verilog/vrt_dram.sv
// DRAM end: reference configuration register and training mode flag.
`timescale 1ns/1ps
module vrt_dram (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    vrt_if.dev bus,
    output logic training_o,
    output logic range_o,
    output logic [5:0] step_code_o,
    output logic pda_o
);
    // ****************************************
    // Decode
    // ****************************************
    logic train_reg;
    logic range_reg;
    logic [5:0] code_reg;
    logic pda_reg;
    wire is_mrs = (bus.cmd == vrt_pkg::VRT_CMD_MRS);
    // With per-device addressing on, a high data bit zero vetoes the command.
    wire mrs_ok = is_mrs && (!pda_reg || !bus.data_bit_zero_o); // [R18]
    wire wr_ref = mrs_ok && (bus.ba == vrt_pkg::REFERENCE_CONFIG_REGISTER);
    wire wr_pda = mrs_ok && (bus.ba == vrt_pkg::PDA_CONFIG_REGISTER);
    wire en_bit = bus.addr[vrt_pkg::TRAIN_EN_BIT];
    wire enter = wr_ref && en_bit && !train_reg; // [R01]
    wire load = wr_ref && en_bit && train_reg; // [R05] [R17]
    wire leave = wr_ref && !en_bit; // [R06] [R09]

    // ****************************************
    // State
    // ****************************************
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            train_reg <= 1'b0; // [R19]
            range_reg <= vrt_pkg::RANGE_RESET;
            code_reg <= vrt_pkg::CODE_RESET;
            pda_reg <= 1'b0;
        end else if (ce_i) begin
            if (enter) begin
                // The step code of the entry command is ignored.
                train_reg <= 1'b1; // [R19]
                range_reg <= bus.addr[vrt_pkg::RANGE_BIT]; // [R01] [R16]
            end else if (load) begin
                range_reg <= bus.addr[vrt_pkg::RANGE_BIT]; // [R17]
                code_reg <= bus.addr[vrt_pkg::CODE_MSB:0]; // [R05]
            end else if (leave) begin
                // Range and code are held as the operating setting.
                train_reg <= 1'b0; // [R09] [R19]
            end
            if (wr_pda) begin
                pda_reg <= bus.addr[vrt_pkg::PDA_EN_BIT];
            end
        end
    end

    assign training_o = train_reg;
    assign range_o = range_reg;
    assign step_code_o = code_reg;
    assign pda_o = pda_reg;
endmodule : vrt_dram

//--- testbench/vrt_check_sva.sv
// Concurrent checks on the command bus and the stored training state.
`timescale 1ns/1ps
module vrt_check (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire vrt_pkg::vrt_cmd_t cmd,
    input wire logic [vrt_pkg::BA_W-1:0] ba,
    input wire logic [vrt_pkg::ADDR_W-1:0] addr,
    input wire logic data_bit_zero_o,
    input wire logic data_bit_zero_oe,
    input wire logic training_o,
    input wire logic range_o,
    input wire logic [5:0] step_code_o,
    input wire logic pda_o
);
    // ****************************************
    // Decoded command classes
    // ****************************************
    wire logic is_mrs = (cmd == vrt_pkg::VRT_CMD_MRS);
    wire logic is_des = (cmd == vrt_pkg::VRT_CMD_DES);
    wire logic runs = is_mrs && (!pda_o || !data_bit_zero_o);
    wire logic ref_cmd = runs && (ba == vrt_pkg::REFERENCE_CONFIG_REGISTER);
    wire logic en_bit = addr[vrt_pkg::TRAIN_EN_BIT];
    wire logic [6:0] code_up = {1'b0, step_code_o} + 7'h01;
    wire logic [6:0] addr_up = {1'b0, addr[5:0]} + 7'h01;
    // A step of more than one code needs the long settle time.
    wire logic big_step = ({1'b0, addr[5:0]} > code_up) || ({1'b0, step_code_o} > addr_up);

    // ****************************************
    // Sequences and assertions
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence seq_enter;
        ref_cmd && en_bit && !training_o;
    endsequence
    sequence seq_exit;
        ref_cmd && !en_bit && training_o;
    endsequence
    sequence seq_des2;
        is_des [*2];
    endsequence

    a_entry_sets_flag: assert property (seq_enter |=> training_o && range_o == $past(addr[6])
        && $stable(step_code_o)) else $error("entry did not set flag and range");
    a_entry_then_wait: assert property (seq_enter |=> seq_des2)
        else $error("command issued inside entry delay");
    a_set_loads_code: assert property (ref_cmd && en_bit && training_o
        |=> step_code_o == $past(addr[5:0])) else $error("step code not loaded");
    a_range_held: assert property (ref_cmd && en_bit && training_o |-> addr[6] == range_o)
        else $error("range changed while training");
    a_long_settle: assert property (ref_cmd && en_bit && training_o && big_step
        |=> is_des [*4]) else $error("long settle time not kept");
    a_bit7_low_keeps: assert property (seq_exit
        |=> !training_o && $stable({range_o, step_code_o})) else $error("exit altered state");
    a_exit_no_value: assert property (seq_exit |-> addr[6:0] == {range_o, step_code_o})
        else $error("exit carried a new value");
    a_exit_then_des: assert property (seq_exit |=> seq_des2)
        else $error("command issued inside exit delay");
    a_bits_locked: assert property (!(ref_cmd && en_bit)
        |=> $stable({range_o, step_code_o})) else $error("range or code changed unasked");
    a_pda_ignores: assert property (is_mrs && pda_o && data_bit_zero_o
        |=> $stable({training_o, range_o, step_code_o, pda_o})) else $error("ignored command ran");
    a_pda_only_mrs: assert property (pda_o |-> is_mrs || is_des)
        else $error("array command while per device addressing");
    a_dq0_on_mrs: assert property (data_bit_zero_oe |-> is_mrs)
        else $error("data bit zero driven outside register write");
endmodule : vrt_check

//--- testbench/dq_reference_training_mode_tb.sv
// Self-checking bench joining the controller and DRAM ends through the command bus.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module dq_reference_training_mode_tb;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic init_done_i = 1'b0;
    logic req_valid_i = 1'b0;
    vrt_pkg::vrt_op_t req_op_i = vrt_pkg::VRT_OP_ENTER;
    logic req_range_i = 1'b0;
    logic [5:0] req_code_i = 6'h00;
    logic [1:0] req_bank_i = 2'h0;
    logic [vrt_pkg::ADDR_W-1:0] req_addr_i = 14'h0123;
    logic req_skip_i = 1'b0;
    logic req_ready_o;
    logic req_err_o;
    logic ctl_training;
    logic dev_training;
    logic range_o;
    logic [5:0] step_code_o;
    logic pda_o;
    int err_count = 0;
    int n_compared = 0;
    logic ob_err;
    vrt_pkg::vrt_cmd_t ob_cmd;
    logic [7:0] ob_addr;
    vrt_pkg::vrt_op_t arr_op [6] = '{vrt_pkg::VRT_OP_WR, vrt_pkg::VRT_OP_ACT, vrt_pkg::VRT_OP_RD,
        vrt_pkg::VRT_OP_RDA, vrt_pkg::VRT_OP_WRA, vrt_pkg::VRT_OP_PRE};
    vrt_pkg::vrt_cmd_t arr_cmd [6] = '{vrt_pkg::VRT_CMD_WR, vrt_pkg::VRT_CMD_ACT,
        vrt_pkg::VRT_CMD_RD, vrt_pkg::VRT_CMD_RDA, vrt_pkg::VRT_CMD_WRA, vrt_pkg::VRT_CMD_PRE};

    vrt_if bus_if();
    vrt_ctrl vrt_ctrl_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
        .init_done_i(init_done_i), .req_valid_i(req_valid_i), .req_op_i(req_op_i),
        .req_range_i(req_range_i), .req_code_i(req_code_i), .req_bank_i(req_bank_i),
        .req_addr_i(req_addr_i), .req_skip_i(req_skip_i), .req_ready_o(req_ready_o),
        .req_err_o(req_err_o), .training_o(ctl_training), .bus(bus_if));
    vrt_dram vrt_dram_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .bus(bus_if),
        .training_o(dev_training), .range_o(range_o), .step_code_o(step_code_o), .pda_o(pda_o));
    vrt_check vrt_check_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .cmd(bus_if.cmd),
        .ba(bus_if.ba), .addr(bus_if.addr), .data_bit_zero_o(bus_if.data_bit_zero_o),
        .data_bit_zero_oe(bus_if.data_bit_zero_oe), .training_o(dev_training),
        .range_o(range_o), .step_code_o(step_code_o), .pda_o(pda_o));

    always #25 clk_i = ~clk_i;

    // ****************************************
    // Tasks
    // ****************************************
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask : tick

    // Waits for ready, holds the request over the taking edge, then samples the bus answer.
    task automatic do_req(input vrt_pkg::vrt_op_t op, input logic rg, input logic [5:0] code,
        input logic [1:0] bank, input logic skip);
        int n;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 50) begin
            tick();
            n++;
        end
        if (n >= 50) begin
            err_count++;
            $display("wrong value at %0t: ready never came", $time);
        end
        req_valid_i = 1'b1;
        req_op_i = op;
        req_range_i = rg;
        req_code_i = code;
        req_bank_i = bank;
        req_skip_i = skip;
        tick();
        // The bus command and the error pulse stand for one cycle after the taking edge.
        ob_err = req_err_o;
        ob_cmd = bus_if.cmd;
        ob_addr = bus_if.addr[7:0];
        req_valid_i = 1'b0;
        tick();
    endtask : do_req

    task automatic print_verdict();
        $display("counts: %0d compared, %0d wrong", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (12) @(posedge clk_i);
        #1;
        arst_n_i = 1'b1;
        tick();
        `CHK({ctl_training, dev_training, range_o, step_code_o, pda_o}, 10'h000)
        do_req(vrt_pkg::VRT_OP_ENTER, 1'b1, 6'h00, 2'h0, 1'b0);
        `CHK(ob_err, 1'b1)
        $display("test reset and init done");
        init_done_i = 1'b1;
        do_req(vrt_pkg::VRT_OP_ENTER, 1'b1, 6'h3f, 2'h0, 1'b0);
        `CHK(ob_addr[7:6], 2'h3)
        tick();
        `CHK({ctl_training, dev_training, range_o, step_code_o}, 9'h1c0)
        for (int i = 0; i < 6; i++) begin
            do_req(arr_op[i], 1'b1, 6'h00, 2'h0, 1'b0);
            `CHK(ob_cmd, arr_cmd[i])
        end
        do_req(vrt_pkg::VRT_OP_SET, 1'b1, 6'h21, 2'h0, 1'b0);
        `CHK(ob_addr, 8'he1)
        tick();
        `CHK(step_code_o, 6'h21)
        do_req(vrt_pkg::VRT_OP_ACT, 1'b1, 6'h00, 2'h2, 1'b0);
        do_req(vrt_pkg::VRT_OP_EXIT, 1'b1, 6'h00, 2'h0, 1'b0);
        `CHK(ob_err, 1'b1)
        do_req(vrt_pkg::VRT_OP_PRE, 1'b1, 6'h00, 2'h2, 1'b0);
        do_req(vrt_pkg::VRT_OP_SET, 1'b1, 6'h22, 2'h0, 1'b0);
        do_req(vrt_pkg::VRT_OP_EXIT, 1'b1, 6'h05, 2'h0, 1'b0);
        `CHK(ob_addr, 8'h62)
        tick();
        `CHK({ctl_training, dev_training, range_o, step_code_o}, 9'h062)
        $display("test training pass done");
        do_req(vrt_pkg::VRT_OP_PDA_ON, 1'b0, 6'h00, 2'h0, 1'b0);
        `CHK(ob_err, 1'b0)
        tick();
        `CHK(pda_o, 1'b1)
        do_req(vrt_pkg::VRT_OP_ACT, 1'b0, 6'h00, 2'h0, 1'b0);
        `CHK(ob_err, 1'b1)
        do_req(vrt_pkg::VRT_OP_ENTER, 1'b0, 6'h00, 2'h0, 1'b0);
        tick();
        `CHK({dev_training, range_o}, 2'h2)
        do_req(vrt_pkg::VRT_OP_SET, 1'b0, 6'h05, 2'h0, 1'b1);
        tick();
        `CHK(step_code_o, 6'h22)
        do_req(vrt_pkg::VRT_OP_SET, 1'b0, 6'h06, 2'h0, 1'b0);
        tick();
        `CHK(step_code_o, 6'h06)
        do_req(vrt_pkg::VRT_OP_RD, 1'b0, 6'h00, 2'h0, 1'b0);
        `CHK(ob_err, 1'b1)
        do_req(vrt_pkg::VRT_OP_EXIT, 1'b0, 6'h00, 2'h0, 1'b0);
        tick();
        `CHK({dev_training, range_o, step_code_o}, 8'h06)
        do_req(vrt_pkg::VRT_OP_PDA_OFF, 1'b0, 6'h00, 2'h0, 1'b0);
        tick();
        `CHK(pda_o, 1'b0)
        $display("test per device addressing done");
        do_req(vrt_pkg::VRT_OP_ENTER, 1'b1, 6'h00, 2'h0, 1'b0);
        tick();
        arst_n_i = 1'b0;
        tick();
        `CHK({ctl_training, dev_training, range_o, step_code_o}, 9'h000)
        tick();
        arst_n_i = 1'b1;
        $display("test reset in training done");
        print_verdict();
    end

    // The whole sequence needs well under a thousand cycles; this margin only cuts a hang.
    initial begin
        #(50 * 4000);
        err_count++;
        print_verdict();
    end
endmodule : dq_reference_training_mode_tb
